// [scd_clock_consumer.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Far side: CPU, peripherals, timers, wake and random logic
// ----------------------------------------------------------------
module scd_clock_consumer (
   // Clock, reset and count clear
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        clr,
   // Ticks: system, peripheral, timer, CPU, slow, random
   input  wire logic [5:0]  ticks,
   // One tick count per consumer
   output logic      [15:0] cnt [6]
);
   // Each consumer only advances on its own enable
   always_ff @(posedge mclk or negedge resetn) begin
      for (int i = 0; i < 6; i++) begin
         if (!resetn) cnt[i] <= 16'h0000;
         else if (clr) cnt[i] <= 16'h0000;
         else if (ticks[i]) cnt[i] <= cnt[i] + 16'h0001;
      end
   end
endmodule : scd_clock_consumer

// [scd_cpu_div.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Shared constants of the clock domain controller
// ----------------------------------------------------------------
package scd_pkg;
   // Rates, in MHz or Hz as printed
   localparam int          SCD_MCLK_MHZ      = 125;
   localparam int          SCD_MCLK_HZ       = 125_000_000;
   localparam int          SCD_XTAL_MHZ      = 32;
   localparam int          SCD_RC_MHZ        = 27;
   localparam int          SCD_RC_TRIM_MHZ   = 32;
   localparam int          SCD_SLOW_HZ       = 32768;
   // Crystal settle budget after reset
   localparam int          SCD_XTAL_WAIT_US  = 1000;
   localparam int          SCD_XTAL_WAIT_CYC = SCD_XTAL_WAIT_US * SCD_MCLK_MHZ;
   // Register byte offsets
   localparam logic [7:0]  SCD_CTRL_OFS      = 8'h00;
   localparam logic [7:0]  SCD_TRIM_OFS      = 8'h04;
   localparam logic [7:0]  SCD_WAKE_OFS      = 8'h08;
   localparam logic [7:0]  SCD_STAT_OFS      = 8'h0c;
   localparam logic [7:0]  SCD_CAL_OFS       = 8'h10;
   localparam logic [7:0]  SCD_CALRES_OFS    = 8'h14;
   // Control field positions
   localparam int          SCD_CTRL_SRC      = 0;
   localparam int          SCD_CTRL_AUTO     = 1;
   localparam int          SCD_CTRL_TFAST    = 2;
   localparam int          SCD_CTRL_DIV      = 4;
   localparam int          SCD_CTRL_SLOW     = 8;
   localparam int          SCD_CTRL_SLEEP    = 12;
   // Reset values and the divider limit
   localparam logic        SCD_SRC_RST       = 1'b1;
   localparam logic        SCD_AUTO_RST      = 1'b1;
   localparam logic [2:0]  SCD_DIV_RST       = 3'h1;
   localparam logic [2:0]  SCD_DIV_MAX       = 3'h5;
   localparam logic [5:0]  SCD_TRIM_RST      = 6'h1b;
   // Slow clock origins
   localparam logic [1:0]  SCD_SLOW_RC       = 2'h0;
   localparam logic [1:0]  SCD_SLOW_XTAL     = 2'h1;
   localparam logic [1:0]  SCD_SLOW_EXT      = 2'h2;
endpackage : scd_pkg

// ----------------------------------------------------------------
// CPU enable divider, changes factor only on a period boundary
// ----------------------------------------------------------------
module scd_cpu_div
   import scd_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // System tick and control
   input  wire logic       sysTick,
   input  wire logic       run,
   input  wire logic [2:0] divReq,
   // CPU enable and current divide factor
   output logic            cpuEn,
   output logic [2:0]      divCur
);
   typedef struct packed {
      logic [4:0] cnt;
      logic [2:0] div;
      logic       en;
   } scd_div_s;

   scd_div_s s_q;
   scd_div_s s_d;

   // Count system ticks; reload and take a new factor only at wrap
   always_comb begin
      s_d    = s_q;
      s_d.en = 1'b0;
      if (sysTick && run) begin
         if (s_q.cnt == 5'h00) begin
            s_d.en  = 1'b1;
            s_d.div = divReq;                               // R18
            s_d.cnt = 5'((6'h01 << divReq) - 6'h01);        // R06
         end else begin
            s_d.cnt = s_q.cnt - 5'h01;
         end
      end
   end

   // State register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '{cnt: 5'h00, div: SCD_DIV_RST, en: 1'b0};  // R16
      end else begin
         s_q <= s_d;
      end
   end

   assign cpuEn  = s_q.en;
   assign divCur = s_q.div;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_div_two_gap : assert property (cpuEn && divCur == 3'h1 |=> !cpuEn [*5]) // R16
      else $error("CPU enable repeats too soon at divide by two");
   a_div_legal : assert property (divCur <= SCD_DIV_MAX) // R15
      else $error("CPU divide factor out of range");
endmodule : scd_cpu_div

// [scd_system_clock_domains.sv]
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// Contract
// R01: Peripheral and CPU clocks from one system clock
// R02: Crystal source gives 32 MHz system rate
// R03: RC source 27 MHz, trimmable toward 32 MHz
// R04: Peripheral clock is half the system rate
// R05: Timers may take full-rate system clock
// R06: CPU clock is system clock divided down
// R07: Slow clock from RC, crystal or module
// R08: Module on pin a, crystal across a and b
// R09: Wake timers count on the slow clock
// R10: Sleep halts CPU until a wake source
// R11: Slow clock runs always, calibrated against peripheral
// R12: Slow clock feeds the random generator
// R13: Software avoids radio while on RC
// R14: Boot on RC, auto switch to crystal
// R15: CPU factors 1, 2, 4, 8, 16, 32 only
// R16: CPU divider resets to divide by two
// R17: Slow source never returns to internal RC
// R18: Source and divider changes are glitch free

module scd_system_clock_domains
   import scd_pkg::*;
#(
   parameter int XTAL_WAIT_CYC = SCD_XTAL_WAIT_CYC
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Oscillator and slow clock pins
   input  wire logic        xtalStable,
   input  wire logic        slow_clock_pin_a,
   input  wire logic        slow_clock_pin_b,
   // Wake sources
   input  wire logic        wakePin,
   input  wire logic        cmpWake,
   input  wire logic        pulseCntWake,
   // Clock enables out
   output logic             sysClkEn,
   output logic             perClkEn,
   output logic             tmrClkEn,
   output logic             cpuClkEn,
   output logic             slowClkEn,
   output logic             rngClkEn,
   // Status out
   output logic             sysOnXtal,
   output logic             cpuHalted,
   output logic             wakeTimerEvt
);
   typedef enum logic [2:0] {
      SYS_BOOT = 3'h1,
      SYS_XTAL = 3'h2,
      SYS_RC   = 3'h4
   } scd_sys_e;

   typedef struct packed {
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      scd_sys_e    sys;
      logic [16:0] bootCnt;
      logic        bootTimeout;
      logic [6:0]  sysAcc;
      logic        sysTick;
      logic        perPhase;
      logic        perTick;
      logic        tmrTick;
      logic        srcXtal;
      logic        autoSw;
      logic        tmrFast;
      logic [2:0]  divReq;
      logic [1:0]  slowSel;
      logic [5:0]  rcInc;
      logic [26:0] slowAcc;
      logic        slowTick;
      logic        pinALast;
      logic [31:0] wakeCnt;
      logic        wakeEvt;
      logic        sleeping;
      logic        calBusy;
      logic        calDone;
      logic [7:0]  calLeft;
      logic [23:0] calCnt;
      logic [31:0] rdata;
      logic        slvErr;
   } scd_state_s;

   scd_state_s s_q;
   scd_state_s s_d;
   logic       cpuEn;
   logic [2:0] divCur;

   // ----------------------------------------------------------------
   // CPU clock divider
   // ----------------------------------------------------------------
   scd_cpu_div u_cpu_div (
      .mclk    (mclk),
      .resetn  (resetn),
      .sysTick (s_q.sysTick),
      .run     (!s_q.sleeping),
      .divReq  (s_q.divReq),
      .cpuEn   (cpuEn),
      .divCur  (divCur)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic        xtalOk;
   logic        pinA;
   logic        pinB;
   logic        wrEn;
   logic        setup;
   logic [7:0]  sysSum;
   logic [5:0]  sysInc;
   logic [27:0] slowSum;
   logic        wakeAny;
   logic [1:0]  newSlow;
   logic [2:0]  newDiv;

   always_comb begin
      s_d        = s_q;
      xtalOk     = s_q.sync2[0];
      pinA       = s_q.sync2[1];
      pinB       = s_q.sync2[2];
      wrEn       = psel && penable && pwrite;
      setup      = psel && !penable;
      newSlow    = pwdata[SCD_CTRL_SLOW +: 2];
      newDiv     = pwdata[SCD_CTRL_DIV +: 3];
      // Two-stage synchronisers for pin and oscillator inputs
      s_d.sync1  = {wakePin, slow_clock_pin_b, slow_clock_pin_a, xtalStable};
      s_d.sync2  = s_q.sync1;
      s_d.pinALast = pinA;

      // Source selection, moved only on a tick boundary
      if (s_q.bootCnt != 17'h00000) begin
         s_d.bootCnt = s_q.bootCnt - 17'h00001;
      end
      case (s_q.sys)
         SYS_BOOT: begin
            if (s_q.bootCnt == 17'h00001 && !xtalOk) begin
               s_d.bootTimeout = 1'b1;
            end
            if (s_q.sysTick && !s_q.autoSw) begin
               s_d.sys = SYS_RC;
            end else if (s_q.sysTick && xtalOk) begin       // R14 R18
               s_d.sys = SYS_XTAL;
            end
         end
         SYS_XTAL: begin
            if (s_q.sysTick && !s_q.srcXtal) begin          // R01 R18
               s_d.sys = SYS_RC;
            end
         end
         SYS_RC: begin
            if (s_q.sysTick && s_q.srcXtal && xtalOk) begin // R01 R18
               s_d.sys = SYS_XTAL;
            end
         end
         default: s_d.sys = SYS_BOOT;
      endcase

      // System tick from a fractional accumulator on mclk
      sysInc = (s_q.sys == SYS_XTAL) ? 6'(SCD_XTAL_MHZ) : s_q.rcInc; // R02 R03
      sysSum = {1'b0, s_q.sysAcc} + {2'h0, sysInc};
      s_d.sysTick = 1'b0;
      s_d.perTick = 1'b0;
      s_d.tmrTick = 1'b0;
      if (sysSum >= 8'(SCD_MCLK_MHZ)) begin
         s_d.sysAcc  = 7'(sysSum - 8'(SCD_MCLK_MHZ));
         s_d.sysTick = 1'b1;
      end else begin
         s_d.sysAcc = 7'(sysSum);
      end
      // Peripheral and timer ticks stop while sleeping
      if (s_d.sysTick && !s_q.sleeping) begin
         s_d.perPhase = !s_q.perPhase;
         s_d.perTick  = s_q.perPhase;                       // R04
         s_d.tmrTick  = s_q.tmrFast ? 1'b1 : s_q.perPhase;  // R05
      end

      // Slow clock tick from the chosen origin
      s_d.slowTick = 1'b0;
      slowSum      = {1'b0, s_q.slowAcc} + 28'(SCD_SLOW_HZ);
      case (s_q.slowSel)
         SCD_SLOW_XTAL: s_d.slowTick = pinA && !s_q.pinALast && !pinB; // R07 R08
         SCD_SLOW_EXT:  s_d.slowTick = pinA && !s_q.pinALast;          // R07 R08
         default: begin
            if (slowSum >= 28'(SCD_MCLK_HZ)) begin                     // R07
               s_d.slowAcc  = 27'(slowSum - 28'(SCD_MCLK_HZ));
               s_d.slowTick = 1'b1;
            end else begin
               s_d.slowAcc = 27'(slowSum);
            end
         end
      endcase

      // Wake timer on the slow clock
      s_d.wakeEvt = 1'b0;
      if (wrEn && paddr == SCD_WAKE_OFS) begin
         s_d.wakeCnt = pwdata;
      end else if (s_q.slowTick && s_q.wakeCnt != 32'h00000000) begin // R09
         s_d.wakeCnt = s_q.wakeCnt - 32'h00000001;
         s_d.wakeEvt = (s_q.wakeCnt == 32'h00000001);
      end

      // Sleep; a wake source beats a sleep request in the same cycle
      wakeAny = s_d.wakeEvt || s_q.sync2[3] || cmpWake || pulseCntWake;
      if (wakeAny) begin
         s_d.sleeping = 1'b0;                                // R10
      end else if (wrEn && paddr == SCD_CTRL_OFS && pwdata[SCD_CTRL_SLEEP]) begin
         s_d.sleeping = 1'b1;                                // R10
      end

      // Calibration: count peripheral ticks over a slow-tick window
      if (wrEn && paddr == SCD_CAL_OFS) begin
         s_d.calBusy = (pwdata[7:0] != 8'h00);
         s_d.calDone = 1'b0;
         s_d.calLeft = pwdata[7:0];
         s_d.calCnt  = 24'h000000;
      end else if (s_q.calBusy) begin
         if (s_q.perTick) begin
            s_d.calCnt = s_q.calCnt + 24'h000001;           // R11
         end
         if (s_q.slowTick) begin
            s_d.calLeft = s_q.calLeft - 8'h01;
            if (s_q.calLeft == 8'h01) begin
               s_d.calBusy = 1'b0;
               s_d.calDone = 1'b1;
            end
         end
      end

      // Register writes
      if (wrEn && paddr == SCD_CTRL_OFS) begin
         s_d.srcXtal = pwdata[SCD_CTRL_SRC];
         s_d.autoSw  = pwdata[SCD_CTRL_AUTO];
         s_d.tmrFast = pwdata[SCD_CTRL_TFAST];
         if (newDiv <= SCD_DIV_MAX) begin
            s_d.divReq = newDiv;                             // R15
         end
         if (newSlow == SCD_SLOW_XTAL || newSlow == SCD_SLOW_EXT) begin
            s_d.slowSel = newSlow;                           // R17
         end
      end else if (wrEn && paddr == SCD_TRIM_OFS) begin
         if (pwdata[5:0] >= 6'(SCD_RC_MHZ) && pwdata[5:0] <= 6'(SCD_RC_TRIM_MHZ)) begin
            s_d.rcInc = pwdata[5:0];                         // R03
         end
      end

      // Read data and error, prepared in the setup cycle
      if (setup) begin
         s_d.rdata  = 32'h00000000;
         s_d.slvErr = 1'b0;
         if (paddr == SCD_CTRL_OFS) begin
            s_d.rdata[SCD_CTRL_SRC]       = s_q.srcXtal;
            s_d.rdata[SCD_CTRL_AUTO]      = s_q.autoSw;
            s_d.rdata[SCD_CTRL_TFAST]     = s_q.tmrFast;
            s_d.rdata[SCD_CTRL_DIV +: 3]  = s_q.divReq;
            s_d.rdata[SCD_CTRL_SLOW +: 2] = s_q.slowSel;
            s_d.rdata[SCD_CTRL_SLEEP]     = s_q.sleeping;
         end else if (paddr == SCD_TRIM_OFS) begin
            s_d.rdata[5:0] = s_q.rcInc;
         end else if (paddr == SCD_WAKE_OFS) begin
            s_d.rdata = s_q.wakeCnt;
         end else if (paddr == SCD_STAT_OFS) begin
            s_d.rdata[5:0] = {s_q.bootTimeout, xtalOk, s_q.calDone, s_q.calBusy,
                              s_q.sleeping, (s_q.sys == SYS_XTAL)};
            s_d.rdata[10:8] = divCur;
         end else if (paddr == SCD_CALRES_OFS) begin
            s_d.rdata[23:0] = s_q.calCnt;
         end else if (paddr != SCD_CAL_OFS) begin
            s_d.slvErr = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_q          <= '0;
         s_q.sys      <= SYS_BOOT;                           // R14
         s_q.bootCnt  <= 17'(XTAL_WAIT_CYC);
         s_q.srcXtal  <= SCD_SRC_RST;
         s_q.autoSw   <= SCD_AUTO_RST;
         s_q.divReq   <= SCD_DIV_RST;                        // R16
         s_q.slowSel  <= SCD_SLOW_RC;                        // R17
         s_q.rcInc    <= SCD_TRIM_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pready       = 1'b1;
   assign prdata       = s_q.rdata;
   assign pslverr      = s_q.slvErr;
   assign sysClkEn     = s_q.sysTick;
   assign perClkEn     = s_q.perTick;
   assign tmrClkEn     = s_q.tmrTick;
   assign cpuClkEn     = cpuEn;
   assign slowClkEn    = s_q.slowTick;                       // R11
   assign rngClkEn     = s_q.slowTick;                       // R12
   assign sysOnXtal    = (s_q.sys == SYS_XTAL);
   assign cpuHalted    = s_q.sleeping;
   assign wakeTimerEvt = s_q.wakeEvt;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence seq_tick_ok;
      s_q.sysTick && s_q.autoSw && xtalOk;
   endsequence
   sequence seq_on_xtal;
      s_q.sys == SYS_XTAL;
   endsequence

   a_boot_switch : assert property (s_q.sys == SYS_BOOT ##0 seq_tick_ok |=> seq_on_xtal) // R14
      else $error("No switch to crystal once stable");
   a_sys_gap : assert property (s_q.sysTick |=> !s_q.sysTick [*2]) // R02
      else $error("System ticks closer than the crystal rate allows");
   a_per_half : assert property (perClkEn |-> sysClkEn ##1 (!perClkEn [*3])) // R04
      else $error("Peripheral tick not at half the system rate");
   a_tmr_fast : assert property (s_q.tmrFast && !s_q.sleeping && s_d.sysTick |=> tmrClkEn) // R05
      else $error("Timer tick missing in full-rate mode");
   a_cpu_halt : assert property (cpuHalted |=> !cpuClkEn) // R10
      else $error("CPU enable while sleeping");
   a_wake_exit : assert property (cpuHalted && (cmpWake || pulseCntWake) |=> !cpuHalted) // R10
      else $error("Wake source did not end sleep");
   a_slow_lock : assert property (s_q.slowSel != SCD_SLOW_RC |=> s_q.slowSel != SCD_SLOW_RC) // R17
      else $error("Slow clock returned to internal oscillator");
   a_rng_slow : assert property (slowClkEn |-> rngClkEn) // R12
      else $error("Random generator clock lost the slow tick");
   a_src_glitch : assert property ($changed(s_q.sys) |-> $past(s_q.sysTick)) // R18
      else $error("System source changed off a tick boundary");
endmodule : scd_system_clock_domains

// [scd_system_clock_domains_tb_top.sv]
`timescale 1ns/1ps

module scd_system_clock_domains_tb_top;
   import scd_pkg::*;
   localparam int WAIT = 200;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, clr, slowOn;
   logic        xtalStable, pinA, pinB, wakePin, cmpWake, pulseWake;
   logic        sysEn, perEn, tmrEn, cpuEn, slowEn, rngEn, onXtal, halted, wakeEvt;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cnt [6];
   logic [15:0] lfsr, c;
   logic [3:0]  n;
   int          nErrors, checked, cyc, div;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} scd_exp_s;
   scd_exp_s    expQ[$];
   scd_exp_s    e;

   scd_system_clock_domains #(.XTAL_WAIT_CYC(WAIT)) scd_system_clock_domains_i (
      .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .xtalStable(xtalStable), .slow_clock_pin_a(pinA), .slow_clock_pin_b(pinB),
      .wakePin(wakePin), .cmpWake(cmpWake), .pulseCntWake(pulseWake),
      .sysClkEn(sysEn), .perClkEn(perEn), .tmrClkEn(tmrEn), .cpuClkEn(cpuEn),
      .slowClkEn(slowEn), .rngClkEn(rngEn), .sysOnXtal(onXtal), .cpuHalted(halted),
      .wakeTimerEvt(wakeEvt));

   scd_clock_consumer scd_clock_consumer_i (.mclk(mclk), .resetn(resetn), .clr(clr),
      .ticks({rngEn, slowEn, cpuEn, tmrEn, perEn, sysEn}), .cnt(cnt));

   // Clock and cycle ceiling
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 90000) begin
         nErrors++;
         final_report();
      end
   end
   // Slow clock module or crystal, period 40 cycles; b is the inverse of a
   always @(posedge mclk) begin
      div <= (div == 19) ? 0 : div + 1;
      if (slowOn && div == 19) pinA <= ~pinA;
      if (slowOn && div == 19) pinB <= pinA;
   end
   // Read monitor: oldest note against the access phase
   always @(posedge mclk) begin
      if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
         e = expQ.pop_front();
         chk(prdata & e.m, e.d & e.m);
         chk(32'(pslverr), 32'(e.e));
      end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task chkr(input logic [31:0] got, input int lo, input int hi);
      checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         nErrors++;
         $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask : chkr
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task rdx(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic er);
      expQ.push_back('{d, m, er});
      apb(1'b0, a, 32'h0);
   endtask : rdx
   task win(input int len);
      repeat (150) @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      repeat (len) @(posedge mclk);
   endtask : win
   task final_report;
      $display("errors %0d checks %0d", nErrors, checked);
      if (nErrors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   function automatic logic [31:0] ctrl(logic s, logic t, logic [2:0] d, logic [1:0] l, logic z);
      return {19'h0, z, 2'h0, l, 1'b0, d, 1'b0, t, 1'b1, s};
   endfunction : ctrl
   function automatic logic [15:0] nxt(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, clr, slowOn, resetn, div} = '0;
      {xtalStable, wakePin, cmpWake, pulseWake} = '0;
      {pinA, pinB} = 2'b11;
      lfsr = 16'h0022;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      // Reset values, refusals, boot on RC
      rdx(SCD_CTRL_OFS, ctrl(1, 0, 1, 0, 0), '1, 1'b0);
      rdx(SCD_TRIM_OFS, 32'h1b, '1, 1'b0);
      rdx(8'h20, 32'h0, '1, 1'b1);
      rdx(SCD_CAL_OFS, 32'h0, '1, 1'b0);
      chk(32'(onXtal), 32'h0);
      win(1000);
      chkr(cnt[0], 214, 218);
      rdx(SCD_STAT_OFS, 32'h20, 32'h31, 1'b0);
      $display("reset and boot test done");
      // Auto switch and crystal rates
      xtalStable <= 1'b1;
      repeat (20) @(posedge mclk);
      chk(32'(onXtal), 32'h1);
      win(1000);
      chkr(cnt[0], 254, 258);
      chkr(cnt[1], 126, 130);
      chkr(cnt[2], 126, 130);
      chkr(cnt[3], 126, 130);
      apb(1'b1, SCD_CTRL_OFS, ctrl(1, 1, 1, 0, 0));
      win(1000);
      chkr(cnt[2], 254, 258);
      for (int d = 0; d < 6; d++) begin
         apb(1'b1, SCD_CTRL_OFS, ctrl(1, 0, 3'(d), 0, 0));
         win(1000);
         chkr(cnt[3], (256 >> d) - 2, (256 >> d) + 2);
         rdx(SCD_STAT_OFS, 32'(d) << 8, 32'h700, 1'b0);
      end
      apb(1'b1, SCD_CTRL_OFS, ctrl(1, 0, 6, 0, 0));
      rdx(SCD_STAT_OFS, 32'h500, 32'h700, 1'b0);
      $display("crystal and divider test done");
      // RC source and trim
      apb(1'b1, SCD_CTRL_OFS, ctrl(0, 0, 1, 0, 0));
      win(1000);
      chk(32'(onXtal), 32'h0);
      chkr(cnt[0], 214, 218);
      apb(1'b1, SCD_TRIM_OFS, 32'h20);
      apb(1'b1, SCD_TRIM_OFS, 32'h28);
      rdx(SCD_TRIM_OFS, 32'h20, 32'h3f, 1'b0);
      win(1000);
      chkr(cnt[0], 254, 258);
      apb(1'b1, SCD_CTRL_OFS, ctrl(1, 0, 1, 0, 0));
      repeat (20) @(posedge mclk);
      chk(32'(onXtal), 32'h1);
      $display("rc test done");
      // Slow domain: internal RC, crystal, module
      win(20000);
      chkr(cnt[4], 4, 6);
      chk(32'(cnt[5]), 32'(cnt[4]));
      slowOn <= 1'b1;
      for (int s = 1; s < 3; s++) begin
         apb(1'b1, SCD_CTRL_OFS, ctrl(1, 0, 1, 2'(s), 0));
         win(2000);
         chkr(cnt[4], 48, 52);
         chk(32'(cnt[5]), 32'(cnt[4]));
      end
      apb(1'b1, SCD_CTRL_OFS, ctrl(1, 0, 1, 0, 0));
      rdx(SCD_CTRL_OFS, 32'h200, 32'h300, 1'b0);
      $display("slow clock test done");
      // Sleep and every wake source
      for (int k = 0; k < 4; k++) begin
         lfsr = nxt(lfsr);
         n = {1'b0, lfsr[2:0]} + 4'h1;
         clr <= 1'b1;
         @(posedge mclk);
         clr <= 1'b0;
         if (k == 0) apb(1'b1, SCD_WAKE_OFS, 32'(n));
         apb(1'b1, SCD_CTRL_OFS, ctrl(1, 0, 1, 2, 1));
         // Let the last CPU tick launched before sleep reach the count
         @(posedge mclk);
         c = cnt[3];
         chk(32'(halted), 32'h1);
         if (k == 0) begin
            for (int i = 0; i < 500 && wakeEvt !== 1'b1; i++) @(posedge mclk);
            chk(32'(wakeEvt), 32'h1);
            chkr(cnt[4], n - 1, n + 1);
         end else begin
            repeat (20 * n) @(posedge mclk);
            chk(32'(cnt[3]), 32'(c));
            wakePin <= (k == 1);
            cmpWake <= (k == 2);
            pulseWake <= (k == 3);
            repeat (3) @(posedge mclk);
            {wakePin, cmpWake, pulseWake} <= 3'b000;
         end
         repeat (8) @(posedge mclk);
         chk(32'(halted), 32'h0);
      end
      $display("sleep and wake test done");
      // Calibration of the slow domain against the peripheral clock
      chk(32'(onXtal), 32'h1);
      // Start the window just after a slow tick so it spans whole periods
      while (slowEn !== 1'b1) @(posedge mclk);
      apb(1'b1, SCD_CAL_OFS, 32'h8);
      while (rd[3] !== 1'b1) apb(1'b0, SCD_STAT_OFS, 32'h0);
      apb(1'b0, SCD_CALRES_OFS, 32'h0);
      chkr(rd, 38, 44);
      $display("calibration test done");
      final_report();
   end
endmodule : scd_system_clock_domains_tb_top
